//--- port_pkg.sv
package port_pkg;

    // ------------------------------------------------------------
    // Timing and size constants
    // ------------------------------------------------------------
    localparam int SYS_CLK_HZ = 40000000;
    localparam int RESET_PULSE_US = 10;
    localparam int RESET_PULSE_CYCLES = (RESET_PULSE_US * (SYS_CLK_HZ / 1000000));
    localparam int BURST_BYTES = 32;
    localparam int MEM_DEPTH = 256;

    // ------------------------------------------------------------
    // Reset values and bus layout
    // ------------------------------------------------------------
    localparam logic [7:0] MEM_RESET_VALUE = 8'h00;
    localparam logic [6:0] TARGET_ADDRESS = 7'h50;
    localparam int FLAG_BASE = 8'h03;
    localparam int FLAG_COUNT = 4;
    localparam int RW_BIT = 0;

    // ------------------------------------------------------------
    // Two-wire target states
    // ------------------------------------------------------------
    typedef enum logic [6:0] {
        TW_IDLE = 7'h01,
        TW_ADDR = 7'h02,
        TW_ADDR_ACK = 7'h04,
        TW_WRITE = 7'h08,
        TW_WRITE_ACK = 7'h10,
        TW_READ = 7'h20,
        TW_READ_ACK = 7'h40
    } tw_state_t;

endpackage

//--- pin_sync.sv
`timescale 1ns/1ps

// Three-stage synchroniser; a change is taken once stages two and three agree.
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // The first stage feeds only the second, never any decision logic.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            stage1 <= RESET_VALUE;
            stage2 <= RESET_VALUE;
            stage3 <= RESET_VALUE;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Each bit is held until two and three agree, which filters one-cycle glitches.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    pin_out[i] <= RESET_VALUE[i];
                end else if (stage2[i] == stage3[i]) begin
                    pin_out[i] <= stage3[i];
                end
            end
        end
    endgenerate

endmodule

//--- pluggable_module_control_port.sv
`timescale 1ns/1ps

// What this block does
// - Selected module answers addressed two-wire commands.
// - Deselected module ignores all bus traffic.
// - Undriven select reads high, deselected.
// - Long reset low restores all defaults.
// - Undriven reset input reads high.
// - Transmitter disabled while held in reset.
// - Undriven low-power request reads asserted.
// - Deasserted request starts hardware-controlled mode.
// - Presence output held low when inserted.
// - Attention pulled low on events, else released.
// - Attention released once set flags read.
// - Target runs up to 400 kbit/s.
// - No clock stretching, bursts of 32 bytes.
// - Bus lines only driven low or released.
// - Squelched transmitter off, modulation off.
// - Receive clock squelched on loss of signal.
module pluggable_module_control_port #(
    parameter int RESET_PULSE = port_pkg::RESET_PULSE_CYCLES,
    parameter logic [6:0] DEVICE_ADDRESS = port_pkg::TARGET_ADDRESS
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic module_select_n,
    input wire logic module_reset_n,
    input wire logic low_power_request,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic scl_out,
    output logic scl_oe,
    output logic sda_out,
    output logic sda_oe,
    output logic module_present_n,
    output logic attention_n_out,
    output logic attention_n_oe,
    input wire logic [port_pkg::FLAG_COUNT-1:0] event_in,
    input wire logic tx_squelch,
    input wire logic rx_los,
    output logic tx_enable,
    output logic tx_modulation_enable,
    output logic rx_clock_enable,
    output logic hardware_mode,
    output logic module_in_reset
);

    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    // Pins reset to high so that undriven pulled-up inputs read high.
    logic sel_n_s;
    logic rst_n_s;
    logic lp_s;
    logic scl_s;
    logic sda_s;

    pin_sync #(
        .WIDTH(5),
        .RESET_VALUE(5'h1F)
    ) u_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .pin_in({module_select_n, module_reset_n, low_power_request, scl_in, sda_in}),
        .pin_out({sel_n_s, rst_n_s, lp_s, scl_s, sda_s})
    );

    // ------------------------------------------------------------
    // Module reset filter
    // ------------------------------------------------------------
    logic [31:0] reset_count;
    logic soft_reset;

    // Only a low level lasting the minimum pulse length resets; short dips are ignored.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            reset_count <= 32'h00000000;
            soft_reset <= 1'b0;
        end else if (rst_n_s) begin
            reset_count <= 32'h00000000;
            soft_reset <= 1'b0;
        end else if (reset_count >= 32'(RESET_PULSE)) begin
            soft_reset <= 1'b1;
        end else begin
            reset_count <= reset_count + 32'h00000001;
        end
    end

    // ------------------------------------------------------------
    // Sideband outputs
    // ------------------------------------------------------------
    // Transmitter stays off while reset is held or squelch is on.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            tx_enable <= 1'b0;
            tx_modulation_enable <= 1'b0;
            rx_clock_enable <= 1'b0;
            module_in_reset <= 1'b1;
            module_present_n <= 1'b0;
        end else begin
            module_in_reset <= !rst_n_s;
            tx_enable <= rst_n_s && !tx_squelch;
            tx_modulation_enable <= rst_n_s && !tx_squelch;
            rx_clock_enable <= !rx_los;
            module_present_n <= 1'b0;
        end
    end

    // Power mode freezes after eight clocks, so the synchroniser's reset value is never latched.
    logic [7:0] init_done;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            init_done <= '0;
            hardware_mode <= 1'b0;
        end else if (soft_reset || !rst_n_s) begin
            init_done <= '0;
            hardware_mode <= 1'b0;
        end else if (!init_done[7]) begin
            init_done <= {init_done[6:0], 1'b1};
            hardware_mode <= !lp_s;
        end
    end

    // ------------------------------------------------------------
    // Two-wire bus conditions
    // ------------------------------------------------------------
    logic scl_d;
    logic sda_d;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign start_cond = scl_s && scl_d && sda_d && !sda_s;
    assign stop_cond = scl_s && scl_d && !sda_d && sda_s;

    // ------------------------------------------------------------
    // Memory and interrupt flags
    // ------------------------------------------------------------
    logic [7:0] mem [port_pkg::MEM_DEPTH];
    logic [port_pkg::FLAG_COUNT-1:0] flags;
    logic [port_pkg::FLAG_COUNT-1:0] flag_read;
    logic mem_we;
    logic [7:0] mem_addr;
    logic [7:0] mem_wdata;

    // Each flag is sticky; an event in the cycle of its read keeps it set.
    genvar f;
    generate
        for (f = 0; f < port_pkg::FLAG_COUNT; f++) begin : g_flag
            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    flags[f] <= 1'b0;
                end else if (soft_reset) begin
                    flags[f] <= 1'b0;
                end else if (event_in[f]) begin
                    flags[f] <= 1'b1;
                end else if (flag_read[f]) begin
                    flags[f] <= 1'b0;
                end
            end
        end
    endgenerate

    // Attention is open-collector: low by driving, high by releasing.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            attention_n_out <= 1'b0;
            attention_n_oe <= 1'b0;
        end else begin
            attention_n_out <= 1'b0;
            attention_n_oe <= |flags;
        end
    end

    // Memory writes; a long reset returns every setting to its default.
    always_ff @(posedge sys_clk) begin
        if (soft_reset) begin
            for (int i = 0; i < port_pkg::MEM_DEPTH; i++) begin
                mem[i] <= port_pkg::MEM_RESET_VALUE;
            end
        end else if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
        end
    end

    // ------------------------------------------------------------
    // Two-wire target engine
    // ------------------------------------------------------------
    port_pkg::tw_state_t state;
    logic [7:0] shift;
    logic [3:0] bit_count;
    logic read_mode;
    logic addr_phase;
    logic ack_drive;
    logic ack_ok;
    logic [7:0] read_byte;

    // Reading the flag address returns the flags as a byte view.
    always_comb begin
        read_byte = mem[mem_addr];
        if (mem_addr == 8'(port_pkg::FLAG_BASE)) begin
            read_byte = {4'h0, flags};
        end
    end

    // SCL sampling only: the target never holds clock low, so no stretching.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state <= port_pkg::TW_IDLE;
            shift <= 8'h00;
            bit_count <= 4'h0;
            read_mode <= 1'b0;
            addr_phase <= 1'b0;
            ack_drive <= 1'b0;
            ack_ok <= 1'b0;
            mem_addr <= 8'h00;
            mem_we <= 1'b0;
            mem_wdata <= 8'h00;
        end else begin
            mem_we <= 1'b0;
            // Write bursts advance only after a stored byte, never after the pointer.
            if (mem_we) begin
                mem_addr <= mem_addr + 8'h01;
            end
            if (sel_n_s || soft_reset) begin
                state <= port_pkg::TW_IDLE;
                ack_drive <= 1'b0;
            end else if (stop_cond) begin
                state <= port_pkg::TW_IDLE;
                ack_drive <= 1'b0;
            end else if (start_cond) begin
                state <= port_pkg::TW_ADDR;
                bit_count <= 4'h0;
                ack_drive <= 1'b0;
            end else begin
                case (state)
                    port_pkg::TW_IDLE: begin
                        ack_drive <= 1'b0;
                    end
                    port_pkg::TW_ADDR: begin
                        if (scl_rise) begin
                            shift <= {shift[6:0], sda_s};
                            bit_count <= bit_count + 4'h1;
                        end else if (scl_fall && bit_count == 4'h8) begin
                            ack_ok <= (shift[7:1] == DEVICE_ADDRESS);
                            read_mode <= shift[port_pkg::RW_BIT];
                            ack_drive <= (shift[7:1] == DEVICE_ADDRESS);
                            addr_phase <= 1'b1;
                            state <= port_pkg::TW_ADDR_ACK;
                        end
                    end
                    port_pkg::TW_ADDR_ACK: begin
                        if (scl_fall) begin
                            bit_count <= 4'h0;
                            ack_drive <= 1'b0;
                            if (!ack_ok) begin
                                state <= port_pkg::TW_IDLE;
                            end else if (read_mode) begin
                                shift <= read_byte;
                                state <= port_pkg::TW_READ;
                            end else begin
                                state <= port_pkg::TW_WRITE;
                            end
                        end
                    end
                    port_pkg::TW_WRITE: begin
                        if (scl_rise) begin
                            shift <= {shift[6:0], sda_s};
                            bit_count <= bit_count + 4'h1;
                        end else if (scl_fall && bit_count == 4'h8) begin
                            if (addr_phase) begin
                                mem_addr <= shift;
                                addr_phase <= 1'b0;
                            end else begin
                                mem_we <= 1'b1;
                                mem_wdata <= shift;
                            end
                            ack_drive <= 1'b1;
                            state <= port_pkg::TW_WRITE_ACK;
                        end
                    end
                    port_pkg::TW_WRITE_ACK: begin
                        if (scl_fall) begin
                            bit_count <= 4'h0;
                            ack_drive <= 1'b0;
                            state <= port_pkg::TW_WRITE;
                        end
                    end
                    port_pkg::TW_READ: begin
                        if (scl_fall && bit_count == 4'h7) begin
                            bit_count <= 4'h8;
                            state <= port_pkg::TW_READ_ACK;
                        end else if (scl_fall) begin
                            shift <= {shift[6:0], 1'b0};
                            bit_count <= bit_count + 4'h1;
                        end
                    end
                    port_pkg::TW_READ_ACK: begin
                        if (scl_rise) begin
                            ack_ok <= !sda_s;
                            mem_addr <= mem_addr + 8'h01;
                        end else if (scl_fall) begin
                            bit_count <= 4'h0;
                            shift <= read_byte;
                            state <= ack_ok ? port_pkg::TW_READ : port_pkg::TW_IDLE;
                        end
                    end
                    default: begin
                        state <= port_pkg::TW_IDLE;
                    end
                endcase
            end
        end
    end

    // Flags count as read once their byte has been shifted out.
    logic [port_pkg::FLAG_COUNT-1:0] read_done;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            read_done <= '0;
        end else begin
            read_done <= (state == port_pkg::TW_READ && scl_fall && bit_count == 4'h7
                          && mem_addr == 8'(port_pkg::FLAG_BASE)) ? flags : '0;
        end
    end
    assign flag_read = read_done;

    // ------------------------------------------------------------
    // Open-drain drivers
    // ------------------------------------------------------------
    // Data is only ever pulled low; clock is never driven at all.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
            scl_out <= 1'b0;
            scl_oe <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            scl_out <= 1'b0;
            scl_oe <= 1'b0;
            if (sel_n_s) begin
                sda_oe <= 1'b0;
            end else if (state == port_pkg::TW_READ) begin
                sda_oe <= !shift[7];
            end else begin
                sda_oe <= ack_drive;
            end
        end
    end

endmodule

//--- port_checker_sva.sv
`timescale 1ns/1ps

// ----
// Port checker
// ----
module port_checker #(
    parameter int RESET_PULSE = 8
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic module_select_n,
    input wire logic module_reset_n,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic module_present_n,
    input wire logic attention_n_out,
    input wire logic attention_n_oe,
    input wire logic [port_pkg::FLAG_COUNT-1:0] event_in,
    input wire logic tx_squelch,
    input wire logic rx_los,
    input wire logic tx_enable,
    input wire logic tx_modulation_enable,
    input wire logic rx_clock_enable,
    input wire logic module_in_reset
);
    // One domain, so clock and reset are given once for every property.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // Eight deselected clocks cover the pin synchroniser and the output flop.
    select_quiet_a: assert property (module_select_n [*8] |-> !sda_oe)
        else $error("data line pulled while deselected");
    open_drain_a: assert property (!scl_out && !sda_out && !attention_n_out)
        else $error("open drain output drives high");
    no_stretch_a: assert property (!scl_oe)
        else $error("serial clock held low by target");
    present_low_a: assert property (!module_present_n)
        else $error("presence released");
    tx_squelch_a: assert property (tx_squelch |=> !tx_enable && !tx_modulation_enable)
        else $error("transmitter on while squelched");
    rx_squelch_a: assert property (rx_los |=> !rx_clock_enable)
        else $error("receive clock on during loss of signal");
    tx_reset_a: assert property (module_in_reset && $past(module_in_reset) |->
        !tx_enable && !tx_modulation_enable)
        else $error("transmitter on in module reset");
    reset_follow_a: assert property (!module_reset_n [*6] |-> module_in_reset)
        else $error("long reset pulse not taken");
    attn_event_a: assert property (|event_in && !module_in_reset |->
        ##[1:3] attention_n_oe)
        else $error("event did not raise attention");
    // Only a flag read while selected, or a module reset, may release it.
    attn_release_a: assert property ($fell(attention_n_oe) |-> module_in_reset ||
        $past(module_in_reset) || !$past(module_select_n, 6))
        else $error("attention released without a read");

    cover property ($rose(attention_n_oe));
    cover property ($rose(sda_oe));
    cover property ($rose(module_in_reset));
endmodule

bind pluggable_module_control_port port_checker #(.RESET_PULSE(RESET_PULSE)) port_checker_i (
    .sys_clk, .resetn, .module_select_n, .module_reset_n, .scl_out, .scl_oe,
    .sda_out, .sda_oe, .module_present_n, .attention_n_out, .attention_n_oe,
    .event_in, .tx_squelch, .rx_los, .tx_enable, .tx_modulation_enable,
    .rx_clock_enable, .module_in_reset
);

//--- host_bus_model.sv
`timescale 1ns/1ps

// ----
// Host two-wire master
// ----
// A bit takes sixteen clocks: data moves one clock after the clock line falls
// and is sampled half a clock before it falls, leaving room for pin synchronisers.
module host_bus_model (
    input wire logic sys_clk,
    input wire logic sda_line,
    output logic scl_drv,
    output logic sda_drv
);
    // Each line is only pulled low or released; one means released.
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic bit_io(input logic b, output logic s);
        tick(1);
        sda_drv <= b;
        tick(7);
        scl_drv <= 1'b1;
        tick(7);
        @(negedge sys_clk) s = sda_line;
        @(posedge sys_clk) scl_drv <= 1'b0;
    endtask

    // The long low time lets a target acknowledge drain before a restart.
    task automatic bus_start();
        tick(1);
        sda_drv <= 1'b1;
        tick(7);
        scl_drv <= 1'b1;
        tick(4);
        sda_drv <= 1'b0;
        tick(4);
        scl_drv <= 1'b0;
    endtask

    task automatic bus_stop();
        tick(1);
        sda_drv <= 1'b0;
        tick(3);
        scl_drv <= 1'b1;
        tick(4);
        sda_drv <= 1'b1;
        tick(8);
    endtask

    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = ~s;
    endtask

    task automatic get_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            d[i] = s;
        end
        bit_io(last, s);
    endtask
endmodule

//--- pluggable_module_control_port_tb.sv
`timescale 1ns/1ps

// ----
// Bench top
// ----
module pluggable_module_control_port_tb;
    localparam int RP = 8;
    localparam int SEL_WAIT = 40;
    localparam int FC = port_pkg::FLAG_COUNT;
    localparam logic [6:0] ADDR = port_pkg::TARGET_ADDRESS;
    logic sys_clk, resetn, module_select_n, module_reset_n, low_power_request;
    logic [FC-1:0] event_in, flags;
    logic tx_squelch, rx_los, scl_out, scl_oe, sda_out, sda_oe, module_present_n;
    logic attention_n_out, attention_n_oe, tx_enable, tx_modulation_enable;
    logic rx_clock_enable, hardware_mode, module_in_reset, host_scl, host_sda;
    logic scl_line, sda_line, attn_line, ack;
    logic [7:0] exp_mem [256];
    logic [7:0] rd;
    int n_mismatch = 0;
    int checks = 0;
    int seed = 32'h7bcf346b;

    // Host pull-ups hold each line high unless some party pulls it low.
    assign scl_line = host_scl & ~(scl_oe & ~scl_out);
    assign sda_line = host_sda & ~(sda_oe & ~sda_out);
    assign attn_line = ~(attention_n_oe & ~attention_n_out);

    pluggable_module_control_port #(.RESET_PULSE(RP)) pluggable_module_control_port_i (
        .sys_clk, .resetn, .module_select_n, .module_reset_n, .low_power_request,
        .scl_in(scl_line), .sda_in(sda_line), .scl_out, .scl_oe, .sda_out, .sda_oe,
        .module_present_n, .attention_n_out, .attention_n_oe, .event_in, .tx_squelch,
        .rx_los, .tx_enable, .tx_modulation_enable, .rx_clock_enable, .hardware_mode,
        .module_in_reset
    );

    host_bus_model host_bus_model_i (.sys_clk, .sda_line, .scl_drv(host_scl), .sda_drv(host_sda));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // A hang anywhere ends in the same closing report.
    initial begin
        repeat (100000) @(posedge sys_clk);
        n_mismatch++;
        final_report();
    end

    function automatic logic [7:0] flag_byte(input logic [FC-1:0] f);
        return 8'(f);
    endfunction

    function automatic logic on_unless(input logic off);
        return ~off;
    endfunction

    task automatic check(input string what, input logic [7:0] e, input logic [7:0] s);
        checks++;
        if (s !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic final_report();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic address(input logic [6:0] a, input logic rw, input logic want);
        host_bus_model_i.bus_start();
        host_bus_model_i.put_byte({a, rw}, ack);
        check("address ack", 8'(want), 8'(ack));
    endtask

    task automatic write_burst(input logic [7:0] ptr, input int n);
        address(ADDR, 1'b0, 1'b1);
        host_bus_model_i.put_byte(ptr, ack);
        for (int i = 0; i < n; i++) begin
            exp_mem[8'(ptr + i)] = 8'($random(seed));
            host_bus_model_i.put_byte(exp_mem[8'(ptr + i)], ack);
            check("write ack", 8'h01, 8'(ack));
        end
        host_bus_model_i.bus_stop();
    endtask

    // Pointer write, repeated start, then reads with a final refusal.
    task automatic read_burst(input logic [7:0] ptr, input int n);
        address(ADDR, 1'b0, 1'b1);
        host_bus_model_i.put_byte(ptr, ack);
        address(ADDR, 1'b1, 1'b1);
        for (int i = 0; i < n; i++) begin
            host_bus_model_i.get_byte(i == n - 1, rd);
            check("read data", exp_mem[8'(ptr + i)], rd);
        end
        host_bus_model_i.bus_stop();
    endtask

    task automatic wait_attn(input logic level);
        int k;
        k = 0;
        while (attn_line !== level && k < 40) begin
            @(posedge sys_clk);
            k++;
        end
        check("attention", 8'(level), 8'(attn_line));
        if (k == 40) begin
            final_report();
        end
    endtask

    initial begin
        resetn = 1'b0;
        module_select_n = 1'b1;
        module_reset_n = 1'b1;
        low_power_request = 1'b0;
        event_in = '0;
        tx_squelch = 1'b0;
        rx_los = 1'b0;
        for (int i = 0; i < 256; i++) exp_mem[i] = port_pkg::MEM_RESET_VALUE;
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (10) @(posedge sys_clk);
        check("present", 8'h00, 8'(module_present_n));
        check("hw mode", 8'h01, 8'(hardware_mode));
        low_power_request <= 1'b1;
        module_select_n <= 1'b0;
        repeat (SEL_WAIT) @(posedge sys_clk);
        check("hw latched", 8'h01, 8'(hardware_mode));
        address(ADDR ^ 7'h01, 1'b0, 1'b0);
        host_bus_model_i.bus_stop();
        write_burst(8'hE0, port_pkg::BURST_BYTES);
        read_burst(8'hE0, port_pkg::BURST_BYTES);
        // Random events raise attention; reading the flag byte clears it.
        for (int j = 0; j < 3; j++) begin
            flags = FC'($random(seed));
            flags[j] = 1'b1;
            event_in <= flags;
            @(posedge sys_clk);
            event_in <= '0;
            wait_attn(1'b0);
            exp_mem[port_pkg::FLAG_BASE] = flag_byte(flags);
            read_burst(8'(port_pkg::FLAG_BASE), 1);
            wait_attn(1'b1);
        end
        for (int j = 0; j < 16; j++) begin
            {tx_squelch, rx_los} <= 2'($random(seed));
            repeat (3) @(posedge sys_clk);
            check("tx enable", 8'(on_unless(tx_squelch)), 8'(tx_enable));
            check("modulation", 8'(on_unless(tx_squelch)), 8'(tx_modulation_enable));
            check("rx clock", 8'(on_unless(rx_los)), 8'(rx_clock_enable));
        end
        tx_squelch <= 1'b0;
        rx_los <= 1'b0;
        // A long module reset must drop the transmitter and clear all state.
        write_burst(8'h40, 4);
        event_in <= FC'(1);
        @(posedge sys_clk);
        event_in <= '0;
        wait_attn(1'b0);
        module_reset_n <= 1'b0;
        repeat (RP + 8) @(posedge sys_clk);
        check("in reset", 8'h01, 8'(module_in_reset));
        check("tx off", 8'h00, 8'(tx_enable));
        module_reset_n <= 1'b1;
        for (int i = 0; i < 256; i++) exp_mem[i] = port_pkg::MEM_RESET_VALUE;
        repeat (10) @(posedge sys_clk);
        check("tx on", 8'h01, 8'(tx_enable));
        wait_attn(1'b1);
        read_burst(8'h40, 4);
        module_select_n <= 1'b1;
        repeat (SEL_WAIT) @(posedge sys_clk);
        address(ADDR, 1'b0, 1'b0);
        host_bus_model_i.bus_stop();
        final_report();
    end
endmodule
